// file: bench/i2c_host_model.sv
// two-wire bus host reading and writing 16-bit device registers
// assumes sda is the resolved line with pull-up; moves on clk falling edges
`timescale 1ns/1ps
`include "pmon_defs.vh"
module i2c_host_model (
	input wire clk,
	input wire sda,
	output reg scl,
	output reg sda_pull
);
	reg [7:0] nack_cnt;
	reg [7:0] hi;
	reg [7:0] lo;
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
		nack_cnt = 8'h00;
	end
	// three clocks a phase leaves room for the one-clock ack delay
	task phase;
	begin
		repeat (3) @(negedge clk);
	end
	endtask
	task start_cond;
	begin
		sda_pull = 1'b0;
		phase;
		scl = 1'b1;
		phase;
		sda_pull = 1'b1;
		phase;
		scl = 1'b0;
		phase;
	end
	endtask
	task stop_cond;
	begin
		sda_pull = 1'b1;
		phase;
		scl = 1'b1;
		phase;
		sda_pull = 1'b0;
		phase;
	end
	endtask
	task send_byte(input [7:0] b);
		integer i;
	begin
		for (i = 7; i >= 0; i = i - 1)
		begin
			sda_pull = ~b[i];
			phase;
			scl = 1'b1;
			phase;
			scl = 1'b0;
		end
		sda_pull = 1'b0;
		phase;
		scl = 1'b1;
		phase;
		if (sda !== 1'b0)
			nack_cnt = nack_cnt + 8'h01;
		scl = 1'b0;
		phase;
	end
	endtask
	// last byte gets no ack so the device lets go of the line
	task recv_byte(input last, output [7:0] b);
		integer i;
	begin
		sda_pull = 1'b0;
		for (i = 7; i >= 0; i = i - 1)
		begin
			phase;
			scl = 1'b1;
			phase;
			b[i] = sda;
			scl = 1'b0;
		end
		sda_pull = ~last;
		phase;
		scl = 1'b1;
		phase;
		scl = 1'b0;
		phase;
	end
	endtask
	task write_reg(input [7:0] p, input [15:0] d);
	begin
		start_cond;
		send_byte({`I2C_ADDR, 1'b0});
		send_byte(p);
		send_byte(d[15:8]);
		send_byte(d[7:0]);
		stop_cond;
	end
	endtask
	task read_reg(input [7:0] p, output [15:0] d);
	begin
		start_cond;
		send_byte({`I2C_ADDR, 1'b0});
		send_byte(p);
		start_cond;
		send_byte({`I2C_ADDR, 1'b1});
		recv_byte(1'b0, hi);
		recv_byte(1'b1, lo);
		stop_cond;
		d = {hi, lo};
	end
	endtask
endmodule

// file: bench/pmon_asserts.sv
// port-level checks for the power monitor block
// assumes one clock clk and srst synchronous active high
`timescale 1ns/1ps
module pmon_asserts #(
	parameter [15:0] CT5_CYC = 16'd10520
) (
	input wire clk,
	input wire srst,
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe,
	input wire [1:0] adc_channel,
	input wire adc_converting,
	input wire sample_strobe,
	input wire results_updated,
	input wire shunt_range,
	input wire [14:0] shunt_scale
);
	// shortest slot: code 0 is 500 cycles unless a shortened code 5 (CT5_CYC) undercuts it
	localparam [15:0] MIN_CT = (CT5_CYC < 16'd500) ? CT5_CYC : 16'd500;
	reg [15:0] gap;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	// cycles since last strobe, saturating so long idle spells stay legal
	always @(posedge clk)
	begin
		if (srst || sample_strobe)
			gap <= 16'h0000;
		else if (gap != 16'hffff)
			gap <= gap + 16'h0001;
	end
	property p_rst_vals;
		$fell(srst) |-> shunt_scale == 15'h1000 && !shunt_range && !adc_converting;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("bad value after reset");
	property p_open_drain;
		sda_out == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("data line driven high");
	property p_oe_scl_low;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
	property p_strobe_pulse;
		sample_strobe |=> !sample_strobe;
	endproperty
	a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
	property p_upd_pulse;
		results_updated |=> !results_updated;
	endproperty
	a_upd_pulse: assert property (p_upd_pulse) else $error("update too long");
	property p_upd_after_sample;
		results_updated |-> sample_strobe || $past(sample_strobe) || $past(sample_strobe, 2);
	endproperty
	a_upd_after_sample: assert property (p_upd_after_sample) else $error("update w/o sample");
	property p_strobe_in_run;
		sample_strobe |-> adc_converting || $past(adc_converting);
	endproperty
	a_strobe_in_run: assert property (p_strobe_in_run) else $error("strobe outside run");
	property p_channel_legal;
		adc_converting |-> adc_channel != 2'd3;
	endproperty
	a_channel_legal: assert property (p_channel_legal) else $error("bad channel");
	property p_min_conv;
		sample_strobe |-> gap >= MIN_CT - 16'd1;
	endproperty
	a_min_conv: assert property (p_min_conv) else $error("conversion too short");
	c_update: cover property (results_updated);
	c_ack: cover property ($rose(sda_oe));
	c_range: cover property ($rose(shunt_range));
endmodule
bind power_monitor_adc_setup_results pmon_asserts #(.CT5_CYC(CT5_CYC)) pmon_asserts_i (
	.clk(clk), .srst(srst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.adc_channel(adc_channel), .adc_converting(adc_converting),
	.sample_strobe(sample_strobe), .results_updated(results_updated),
	.shunt_range(shunt_range), .shunt_scale(shunt_scale));

// file: bench/testbench.sv
// register traffic and conversion timing tests for the power monitor
// assumes the host model on the bus and shortened slow conversion codes
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0;
	reg srst = 1'b1;
	wire scl, host_pull, sda_out, sda_oe, adc_converting, sample_strobe;
	wire results_updated, shunt_range;
	wire [1:0] adc_channel;
	wire [14:0] shunt_scale;
	// pull-up line: low when either side pulls
	wire sda = ~(host_pull | (sda_oe & ~sda_out));
	integer fail_count = 0;
	integer num_checks = 0;
	integer n, t, k;
	integer per [0:3];
	reg [15:0] rv;
	reg [15:0] bus_sample = 16'h1234;
	always #50 clk = ~clk;
	power_monitor_adc_setup_results #(.CT5_CYC(16'd20), .CT6_CYC(16'd30), .CT7_CYC(16'd50))
		power_monitor_adc_setup_results_i (.clk(clk), .srst(srst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .adc_bus_sample(bus_sample),
		.adc_shunt_sample(16'hfe00), .adc_temp_sample(12'h123), .adc_channel(adc_channel),
		.adc_converting(adc_converting), .sample_strobe(sample_strobe),
		.results_updated(results_updated), .shunt_range(shunt_range),
		.shunt_scale(shunt_scale));
	i2c_host_model i2c_host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_pull(host_pull));
	task print_verdict;
	begin
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task check(input [95:0] what, input [31:0] seen, input [31:0] exp);
	begin
		num_checks = num_checks + 1;
		if (seen !== exp)
		begin
			fail_count = fail_count + 1;
			$display("ERROR %0s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task wr(input [7:0] p, input [15:0] d);
	begin
		i2c_host_model_i.write_reg(p, d);
	end
	endtask
	task rdc(input [7:0] p, input [15:0] e, input [95:0] what);
	begin
		i2c_host_model_i.read_reg(p, rv);
		check(what, rv, e);
	end
	endtask
	// counts cycles to the next update and strobes on the way; long waits must end
	task wait_upd(input integer lim);
	begin
		t = 0;
		do
		begin
			@(negedge clk);
			t = t + 1;
			if (sample_strobe === 1'b1)
				k = k + 1;
		end
		while (results_updated !== 1'b1 && t < lim);
		if (lim > 300 && t >= lim)
		begin
			check("no update", 0, 1);
			print_verdict;
		end
	end
	endtask
	initial
	begin
		repeat (2) @(negedge clk);
		srst = 1'b0;
		check("scale port", shunt_scale, 15'h1000);
		check("range port", shunt_range, 1'b0);
		rdc(8'h01, 16'hfb68, "setup");
		check("shunt ct", rv[8:6], 3'h5);
		check("temp ct", rv[5:3], 3'h5);
		check("avg", rv[2:0], 3'h0);
		check("mode", rv[15:12], 4'hf);
		rdc(8'h02, 16'h1000, "scale");
		rdc(8'h09, 16'h0000, "unmapped");
		for (n = 4; n < 7; n = n + 1)
			wr(n, 16'hffff);
		rdc(8'h04, 16'hfe00, "shunt res");
		rdc(8'h05, 16'h1234, "bus res");
		rdc(8'h06, 16'h1230, "temp res");
		$display("test reset_and_results done");
		wr(8'h02, 16'hffff);
		rdc(8'h02, 16'h7fff, "scale rw");
		check("scale port", shunt_scale, 15'h7fff);
		wr(8'h00, 16'h0010);
		check("range port", shunt_range, 1'b1);
		// soft reset restores the scale; its write must still be acknowledged
		wr(8'h00, 16'h8000);
		check("range soft", shunt_range, 1'b0);
		rdc(8'h02, 16'h1000, "soft rst");
		$display("test scale_and_range done");
		// all three channels, four samples each
		wr(8'h01, 16'hfd69);
		k = 0;
		wait_upd(40000);
		check("all ch avg", k, 12);
		// shunt only, every averaging code
		for (n = 0; n < 8; n = n + 1)
		begin
			wr(8'h01, 16'haba8 | n);
			k = 0;
			wait_upd(40000);
			check("avg count", k, n < 4 ? (1 << (2 * n)) : (128 << (n - 4)));
		end
		$display("test averaging done");
		// slowest against fastest code, shunt then temperature
		for (n = 0; n < 4; n = n + 1)
		begin
			wr(8'h01, n == 0 ? 16'haa28 : n == 1 ? 16'habe8 : n == 2 ? 16'hcb40 : 16'hcb78);
			wait_upd(40000);
			wait_upd(40000);
			per[n] = t;
		end
		check("shunt ct", per[0] - per[1], 450);
		check("temp ct", per[2] - per[3], 450);
		$display("test conversion_time done");
		// a negative bus code must read back as zero
		bus_sample = 16'hf000;
		wr(8'h01, 16'h7b68);
		wait_upd(40000);
		wait_upd(300);
		check("one shot", t + results_updated, 300);
		check("idle", adc_converting, 1'b0);
		rdc(8'h05, 16'h0000, "bus clamp");
		wr(8'h01, 16'h0b68);
		wait_upd(300);
		check("shutdown", t + results_updated, 300);
		check("nacks", i2c_host_model_i.nack_cnt, 8'h00);
		$display("test modes done");
		print_verdict;
	end
endmodule

// file: design/pmon_i2c_slave.v
// two-wire bus slave: address byte, register pointer byte, 16-bit words msb first
// assumes scl and sda inputs already synchronous to clk; sda is open drain
`timescale 1ns/1ps
`include "pmon_defs.vh"

module pmon_i2c_slave #(
	parameter [6:0] DEV_ADDR = `I2C_ADDR
) (
	input wire clk,
	input wire srst,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	output reg [7:0] reg_ptr,
	output reg wr_en,
	output reg [15:0] wr_data,
	input wire [15:0] rd_data
);
	localparam ST_IDLE = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_PTR = 3'd2;
	localparam ST_WDATA = 3'd3;
	localparam ST_RDATA = 3'd4;

	reg [2:0] state;
	reg scl_d;
	reg sda_d;
	reg [7:0] sh;
	reg [3:0] cnt;
	reg [15:0] tx;
	reg hi_done;
	reg rw;
	reg drive_low;
	wire start_c;
	wire stop_c;
	wire scl_rise;
	wire scl_fall;

	// bus conditions from previous and present pin levels
	assign start_c = scl_in & scl_d & sda_d & ~sda_in;
	assign stop_c = scl_in & scl_d & ~sda_d & sda_in;
	assign scl_rise = scl_in & ~scl_d;
	assign scl_fall = ~scl_in & scl_d;
	assign sda_out = 1'b0; // open drain, only ever pulls low
	assign sda_oe = drive_low;

	// byte engine; cnt 0..7 data bits, 8 byte complete, 9 acknowledge slot
	always @(posedge clk)
	begin
		wr_en <= 1'b0;
		if (srst)
		begin
			state <= ST_IDLE;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			sh <= 8'h00;
			cnt <= 4'h0;
			tx <= 16'h0000;
			hi_done <= 1'b0;
			rw <= 1'b0;
			drive_low <= 1'b0;
			reg_ptr <= 8'h00;
			wr_data <= 16'h0000;
		end
		else
		begin
			scl_d <= scl_in;
			sda_d <= sda_in;
			if (start_c)
			begin
				state <= ST_ADDR;
				cnt <= 4'h0;
				drive_low <= 1'b0;
			end
			else if (stop_c)
			begin
				state <= ST_IDLE;
				drive_low <= 1'b0;
			end
			else if (state == ST_RDATA)
			begin
				if (scl_rise && cnt < 4'd8)
					cnt <= cnt + 4'd1;
				else if (scl_rise && cnt == 4'd9 && sda_in)
				begin
					// master refused the byte: read ends
					state <= ST_IDLE;
				end
				else if (scl_fall && cnt < 4'd8)
				begin
					tx <= {tx[14:0], 1'b0};
					drive_low <= ~tx[14];
				end
				else if (scl_fall && cnt == 4'd8)
				begin
					tx <= {tx[14:0], 1'b0};
					drive_low <= 1'b0;
					cnt <= 4'd9;
				end
				else if (scl_fall && cnt == 4'd9)
				begin
					// after the low byte the word is fetched again for repeated reads
					cnt <= 4'h0;
					hi_done <= ~hi_done;
					if (hi_done)
					begin
						tx <= rd_data;
						drive_low <= ~rd_data[15];
					end
					else
						drive_low <= ~tx[15];
				end
			end
			else if (state != ST_IDLE)
			begin
				if (scl_rise && cnt < 4'd8)
				begin
					sh <= {sh[6:0], sda_in};
					cnt <= cnt + 4'd1;
				end
				else if (scl_fall && cnt == 4'd8)
				begin
					cnt <= 4'd9;
					drive_low <= 1'b1;
					case (state)
						ST_ADDR:
						begin
							rw <= sh[0];
							if (sh[7:1] != DEV_ADDR)
							begin
								state <= ST_IDLE;
								drive_low <= 1'b0;
							end
						end
						ST_PTR:
							reg_ptr <= sh;
						ST_WDATA:
						begin
							if (hi_done)
							begin
								wr_data <= {wr_data[15:8], sh};
								wr_en <= 1'b1;
							end
							else
								wr_data <= {sh, wr_data[7:0]};
						end
						default:
							state <= ST_IDLE;
					endcase
				end
				else if (scl_fall && cnt == 4'd9)
				begin
					cnt <= 4'h0;
					case (state)
						ST_ADDR:
						begin
							hi_done <= 1'b0;
							if (rw)
							begin
								state <= ST_RDATA;
								tx <= rd_data;
								drive_low <= ~rd_data[15];
							end
							else
							begin
								state <= ST_PTR;
								drive_low <= 1'b0;
							end
						end
						ST_PTR:
						begin
							state <= ST_WDATA;
							drive_low <= 1'b0;
						end
						default:
						begin
							hi_done <= ~hi_done;
							drive_low <= 1'b0;
						end
					endcase
				end
			end
		end
	end
endmodule

// file: design/power_monitor_adc_setup_results.v
// conversion setup, shunt scale constant and measurement result registers of a power monitor
// assumes sample inputs hold a settled converter code for the channel on adc_channel
`timescale 1ns/1ps
`include "pmon_defs.vh"

module power_monitor_adc_setup_results #(
	parameter [6:0] DEV_ADDR = `I2C_ADDR,
	parameter [15:0] CT5_CYC = `CT5_US * `CLK_MHZ,
	parameter [15:0] CT6_CYC = `CT6_US * `CLK_MHZ,
	parameter [15:0] CT7_CYC = `CT7_US * `CLK_MHZ
) (
	input wire clk,
	input wire srst,
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	input wire [15:0] adc_bus_sample,
	input wire [15:0] adc_shunt_sample,
	input wire [11:0] adc_temp_sample,
	output reg [1:0] adc_channel,
	output reg adc_converting,
	output reg sample_strobe,
	output reg results_updated,
	output reg shunt_range,
	output reg [14:0] shunt_scale
);
	localparam [15:0] CT0_CYC = `CT0_US * `CLK_MHZ;
	localparam [15:0] CT1_CYC = `CT1_US * `CLK_MHZ;
	localparam [15:0] CT2_CYC = `CT2_US * `CLK_MHZ;
	localparam [15:0] CT3_CYC = `CT3_US * `CLK_MHZ;
	localparam [15:0] CT4_CYC = `CT4_US * `CLK_MHZ;
	localparam ENG_IDLE = 1'b0;
	localparam ENG_CONV = 1'b1;
	localparam ACC_W = 26;
	localparam [15:0] CFG_INIT = `CFG_RESET;

	reg soft_rst;
	wire rst_all;
	reg [15:0] conversion_setup;
	reg [15:0] shunt_voltage_result;
	reg [15:0] bus_voltage_result;
	reg [15:0] die_temperature_result;
	reg [15:0] rd_data;
	wire [7:0] reg_ptr;
	wire wr_en;
	wire [15:0] wr_data;
	wire setup_wr;
	wire [3:0] op_mode;
	wire [2:0] chan_en;
	wire [2:0] shunt_conv_time;
	wire [2:0] temp_conv_time;
	wire [2:0] bus_conv_time;
	wire [2:0] sample_average_select;
	reg eng_state;
	reg single_pending;
	reg [15:0] timer;
	reg [10:0] rounds;
	reg [3:0] avg_shift;
	wire take;
	wire [47:0] samples;
	wire [47:0] avg_flat;
	wire [3*ACC_W-1:0] sum_flat;
	reg [2:0] next_sel;
	reg [2:0] first_sel;
	reg [2:0] ct_code;

	// register bus; only the pointer, a write pulse with its data word and the read word cross over
	pmon_i2c_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_bus (
		.clk(clk),
		.srst(srst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.reg_ptr(reg_ptr),
		.wr_en(wr_en),
		.wr_data(wr_data),
		.rd_data(rd_data)
	);

	// soft reset a cycle after the write; the bus slave is spared so the ack stands
	assign rst_all = srst | soft_rst;
	assign setup_wr = wr_en && reg_ptr == `OFS_CONVERSION_SETUP;

	// setup field views
	assign op_mode = conversion_setup[`SETUP_MODE_HI:`SETUP_MODE_LO];
	assign chan_en = op_mode[2:0]; // bit0 bus, bit1 shunt, bit2 temperature
	assign bus_conv_time = conversion_setup[`SETUP_BUS_CT_HI:`SETUP_BUS_CT_LO];
	assign shunt_conv_time = conversion_setup[`SETUP_SHUNT_CT_HI:`SETUP_SHUNT_CT_LO];
	assign temp_conv_time = conversion_setup[`SETUP_TEMP_CT_HI:`SETUP_TEMP_CT_LO];
	assign sample_average_select = conversion_setup[`SETUP_AVG_HI:`SETUP_AVG_LO];

	// writable registers; result offsets are absent so writes there fall away
	always @(posedge clk)
	begin
		if (rst_all)
		begin
			soft_rst <= 1'b0;
			shunt_range <= CFG_INIT[`CFG_RANGE_BIT];
			conversion_setup <= `SETUP_RESET;
			shunt_scale <= `SCALE_RESET;
		end
		else
		begin
			soft_rst <= 1'b0;
			if (wr_en)
			begin
				case (reg_ptr)
					`OFS_DEVICE_CONFIG:
					begin
						soft_rst <= wr_data[`CFG_SOFT_RESET_BIT];
						shunt_range <= wr_data[`CFG_RANGE_BIT];
					end
					`OFS_CONVERSION_SETUP:
						conversion_setup <= wr_data;
					`OFS_SHUNT_SCALE:
						shunt_scale <= wr_data[`SCALE_HI:0];
					default:
						soft_rst <= 1'b0;
				endcase
			end
		end
	end

	// read mux; unused offsets and reserved bits read zero
	always @*
	begin
		case (reg_ptr)
			`OFS_DEVICE_CONFIG:
				rd_data = {11'h000, shunt_range, 4'h0};
			`OFS_CONVERSION_SETUP:
				rd_data = conversion_setup;
			`OFS_SHUNT_SCALE:
				rd_data = {1'b0, shunt_scale};
			`OFS_SHUNT_RESULT:
				rd_data = shunt_voltage_result;
			`OFS_BUS_RESULT:
				rd_data = bus_voltage_result;
			`OFS_TEMP_RESULT:
				rd_data = die_temperature_result;
			default:
				rd_data = 16'h0000;
		endcase
	end

	// averaging code to divide shift; the sample count is one shifted by it
	always @*
	begin
		case (sample_average_select)
			3'd0: avg_shift = 4'd0;
			3'd1: avg_shift = 4'd2;
			3'd2: avg_shift = 4'd4;
			3'd3: avg_shift = 4'd6;
			3'd4: avg_shift = 4'd7;
			3'd5: avg_shift = 4'd8;
			3'd6: avg_shift = 4'd9;
			default: avg_shift = 4'd10;
		endcase
	end

	// conversion time code of the channel that is about to convert
	always @*
	begin
		case (next_sel[1:0])
			2'd0: ct_code = bus_conv_time;
			2'd1: ct_code = shunt_conv_time;
			default: ct_code = temp_conv_time;
		endcase
	end

	// code to cycles; long times are parameters so a bench can shorten them
	function [15:0] ct_cycles;
		input [2:0] code;
		begin
			case (code)
				3'd0: ct_cycles = CT0_CYC;
				3'd1: ct_cycles = CT1_CYC;
				3'd2: ct_cycles = CT2_CYC;
				3'd3: ct_cycles = CT3_CYC;
				3'd4: ct_cycles = CT4_CYC;
				3'd5: ct_cycles = CT5_CYC;
				3'd6: ct_cycles = CT6_CYC;
				default: ct_cycles = CT7_CYC;
			endcase
		end
	endfunction

	// next enabled channel after the current one, and the first enabled one;
	// bit 2 of each says whether such a channel exists
	always @*
	begin
		next_sel = 3'b000;
		first_sel = 3'b000;
		if (chan_en[0])
			first_sel = 3'b100;
		else if (chan_en[1])
			first_sel = 3'b101;
		else if (chan_en[2])
			first_sel = 3'b110;
		if (adc_channel == 2'd0 && chan_en[1])
			next_sel = 3'b101;
		else if (adc_channel != 2'd2 && chan_en[2])
			next_sel = 3'b110;
		if (eng_state == ENG_IDLE || !next_sel[2])
			next_sel = first_sel;
	end

	assign take = eng_state == ENG_CONV && timer == 16'd1;
	assign samples = {{4{adc_temp_sample[11]}}, adc_temp_sample, adc_shunt_sample,
		adc_bus_sample};

	// one signed accumulator per channel, each fed by the same round count
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1)
		begin : g_acc
			reg signed [ACC_W-1:0] acc;
			wire signed [ACC_W-1:0] sext;
			wire [ACC_W-1:0] quot;
			assign sext = {{(ACC_W-16){samples[gi*16+15]}}, samples[gi*16 +: 16]};
			assign quot = sum_flat[gi*ACC_W +: ACC_W] >> avg_shift; // kept bits stop below top except at shift 10
			assign avg_flat[gi*16 +: 16] = quot[15:0];
			assign sum_flat[gi*ACC_W +: ACC_W] = (take && adc_channel == gi) ?
				acc + sext : acc;
			// cleared at each run start so every channel averages the same count
			always @(posedge clk)
			begin
				if (rst_all || setup_wr || (eng_state == ENG_IDLE))
					acc <= {ACC_W{1'b0}};
				else if (take && adc_channel == gi)
					acc <= acc + sext;
			end
		end
	endgenerate

	// conversion sequencer: one round visits each enabled channel once
	always @(posedge clk)
	begin
		sample_strobe <= 1'b0;
		results_updated <= 1'b0;
		if (rst_all)
		begin
			eng_state <= ENG_IDLE;
			single_pending <= 1'b0;
			timer <= 16'h0000;
			rounds <= 11'h000;
			adc_channel <= 2'd0;
			adc_converting <= 1'b0;
			shunt_voltage_result <= 16'h0000;
			bus_voltage_result <= 16'h0000;
			die_temperature_result <= 16'h0000;
		end
		else if (setup_wr)
		begin
			// a new setup abandons any run; a single-shot setup arms one run at once
			eng_state <= ENG_IDLE;
			adc_converting <= 1'b0;
			single_pending <= ~wr_data[`SETUP_MODE_HI];
		end
		else
		begin
			case (eng_state)
				ENG_IDLE:
				begin
					if (first_sel[2] && (op_mode[3] || single_pending))
					begin
						single_pending <= 1'b0;
						eng_state <= ENG_CONV;
						adc_converting <= 1'b1;
						adc_channel <= first_sel[1:0];
						timer <= ct_cycles(ct_code);
						rounds <= 11'h000;
					end
				end
				ENG_CONV:
				begin
					if (take)
					begin
						sample_strobe <= 1'b1;
						adc_channel <= next_sel[1:0];
						timer <= ct_cycles(ct_code);
						if (next_sel == first_sel)
						begin
							rounds <= rounds + 11'd1;
							if (rounds + 11'd1 == (11'd1 << avg_shift))
							begin
								// only a finished run reaches the results
								eng_state <= ENG_IDLE;
								adc_converting <= 1'b0;
								results_updated <= 1'b1;
								if (chan_en[0])
									bus_voltage_result <= avg_flat[15] ? 16'h0000 : avg_flat[15:0];
								if (chan_en[1])
									shunt_voltage_result <= avg_flat[31:16];
								if (chan_en[2])
									die_temperature_result <= {avg_flat[43:32], 4'h0};
							end
						end
					end
					else
						timer <= timer - 16'd1;
				end
				default:
					eng_state <= ENG_IDLE;
			endcase
		end
	end

	// shunt_scale leaves as a port: the current path takes its lsb weight from it
	// shunt weight follows shunt_range: 5 uV at 0, 1.25 uV at 1
	// results fill from reset too: the reset setup converts all three channels continuously
endmodule

// file: shared/pmon_defs.vh
// register offsets, field positions, reset values and conversion timing for the power monitor
// assumes a 10 MHz system clock; included by bare name from the design files
`ifndef PMON_DEFS_VH
`define PMON_DEFS_VH

// register pointer values
`define OFS_DEVICE_CONFIG 8'h00
`define OFS_CONVERSION_SETUP 8'h01
`define OFS_SHUNT_SCALE 8'h02
`define OFS_SHUNT_RESULT 8'h04
`define OFS_BUS_RESULT 8'h05
`define OFS_TEMP_RESULT 8'h06

// device configuration fields
`define CFG_SOFT_RESET_BIT 15
`define CFG_RANGE_BIT 4
`define CFG_RESET 16'h0000

// conversion setup fields and reset
`define SETUP_MODE_HI 15
`define SETUP_MODE_LO 12
`define SETUP_BUS_CT_HI 11
`define SETUP_BUS_CT_LO 9
`define SETUP_SHUNT_CT_HI 8
`define SETUP_SHUNT_CT_LO 6
`define SETUP_TEMP_CT_HI 5
`define SETUP_TEMP_CT_LO 3
`define SETUP_AVG_HI 2
`define SETUP_AVG_LO 0
`define SETUP_RESET 16'hfb68

// shunt scale constant
`define SCALE_HI 14
`define SCALE_RESET 15'h1000

// temperature result: 12 bits at the top, low nibble zero
`define TEMP_LO 4

// conversion times in microseconds and clock rate in MHz
`define CLK_MHZ 10
`define CT0_US 50
`define CT1_US 84
`define CT2_US 150
`define CT3_US 280
`define CT4_US 540
`define CT5_US 1052
`define CT6_US 2074
`define CT7_US 4120

// i2c slave address default
`define I2C_ADDR 7'h40

`endif
